// ===== shared/hbc_pkg.sv
// package: constants and carrier types for the bridge control block
package hbc_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int DEAD_TIME_NS = 200;
  localparam int DEAD_CYCLES = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DEGLITCH_NS = 500;
  localparam int DEGLITCH_CYCLES = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] DEAD_CNT = CNT_W'(DEAD_CYCLES);
  localparam logic [CNT_W-1:0] DEGLITCH_CNT = CNT_W'(DEGLITCH_CYCLES);
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;

  // ----------------------------------------
  // register map (plain port, word per register)
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_GAIN = 4'h1;
  localparam logic [3:0] ADDR_STATUS = 4'h2;
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_SCHEME_BIT = 1;
  localparam int CTRL_IN_A_BIT = 2;
  localparam int CTRL_IN_B_BIT = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [2:0] GAIN_RESET = 3'h0;

  // ----------------------------------------
  // terminal drive and bridge states
  // ----------------------------------------
  typedef enum logic [1:0] {
    TERM_Z = 2'h0,
    TERM_LOW = 2'h1,
    TERM_HIGH = 2'h2
  } hbc_term_e;

  typedef enum logic [2:0] {
    BR_COAST = 3'h0,
    BR_REVERSE = 3'h1,
    BR_FORWARD = 3'h2,
    BR_BRAKE = 3'h3,
    BR_SLEEP = 3'h4
  } hbc_bridge_e;

  // gain decode results
  localparam logic [1:0] GAIN_LOW = 2'h0;
  localparam logic [1:0] GAIN_MID = 2'h1;
  localparam logic [1:0] GAIN_HIGH = 2'h2;
  localparam logic [1:0] RDS_120 = 2'h0;
  localparam logic [1:0] RDS_440 = 2'h1;
  localparam logic [1:0] RDS_2040 = 2'h2;
  localparam logic [1:0] OCP_4A = 2'h0;
  localparam logic [1:0] OCP_800MA = 2'h1;
  localparam logic [1:0] OCP_160MA = 2'h2;
  // max current code: 0=4A 1=2A 2=1A 3=0.5A 4=0.25A 5=0.125A
  localparam logic [2:0] IMAX_4A = 3'h0;
  localparam logic [2:0] IMAX_2A = 3'h1;
  localparam logic [2:0] IMAX_1A = 3'h2;
  localparam logic [2:0] IMAX_500MA = 3'h3;
  localparam logic [2:0] IMAX_250MA = 3'h4;
  localparam logic [2:0] IMAX_125MA = 3'h5;

  typedef struct packed {
    logic [1:0] mirror_gain;
    logic [1:0] low_side_rds;
    logic [1:0] overcurrent_limit;
    logic [2:0] max_current;
  } hbc_gain_s;

  typedef struct packed {
    hbc_term_e term_a;
    hbc_term_e term_b;
  } hbc_drive_s;

endpackage : hbc_pkg

// ===== rtl/hbc_deglitch.sv
// module: three-stage synchroniser with deglitch filter for one pin
module hbc_deglitch
  import hbc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin,
  output logic level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic [CNT_W-1:0] cnt;
  } hbc_dg_s;

  hbc_dg_s st_reg;
  hbc_dg_s st_next;

  // ----------------------------------------
  // filter: s1 feeds only s2; a change counts once s2 and s3 agree
  // and then holds for the deglitch count
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.s1 = pin;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    if ((st_reg.s2 == st_reg.s3) && (st_reg.s3 != st_reg.level)) begin
      if (st_reg.cnt >= DEGLITCH_CNT - CNT_ONE) begin
        st_next.level = st_reg.s3;
        st_next.cnt = CNT_ZERO;
      end else begin
        st_next.cnt = st_reg.cnt + CNT_ONE;
      end
    end else begin
      st_next.cnt = CNT_ZERO; // short pulse restarts the filter
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign level = st_reg.level;

  stable_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
    $changed(level) |-> $past(st_reg.s3, 1) == level)
    else $error("deglitched level changed against synchronised input");

endmodule : hbc_deglitch

// ===== rtl/hbc_gain_decode.sv
// module: sense gain select decode to gain, on-resistance and limits
module hbc_gain_decode
  import hbc_pkg::*;
(
  input wire logic [2:0] gain_select,
  output hbc_gain_s gain
);

  // ----------------------------------------
  // decode; middle bit ignored in the top range
  // ----------------------------------------
  always_comb begin
    gain = '0;
    case (gain_select)
      3'h0: begin
        gain = '{GAIN_LOW, RDS_120, OCP_4A, IMAX_4A};
      end
      3'h1: begin
        gain = '{GAIN_LOW, RDS_120, OCP_4A, IMAX_2A};
      end
      3'h2: begin
        gain = '{GAIN_MID, RDS_440, OCP_800MA, IMAX_1A};
      end
      3'h3: begin
        gain = '{GAIN_MID, RDS_440, OCP_800MA, IMAX_500MA};
      end
      3'h4, 3'h6: begin
        gain = '{GAIN_HIGH, RDS_2040, OCP_160MA, IMAX_250MA};
      end
      3'h5, 3'h7: begin
        gain = '{GAIN_HIGH, RDS_2040, OCP_160MA, IMAX_125MA};
      end
      default: begin
        gain = '0;
      end
    endcase
  end

endmodule : hbc_gain_decode

// ===== rtl/hbc_bridge_ctrl.sv
// module: full-bridge input select, decode, dead time and sense gating
//
// Functional notes
// - source select picks pins or register bits
// - scheme bit picks phase/enable or PWM
// - sleep holds both terminals high impedance
// - phase/enable truth table: reverse, forward, brake
// - PWM table: coast, reverse, forward, brake
// - first input is enable, second is phase
// - dead time on every high/low reversal
// - input pins deglitched before reaching outputs
// - gain select sets mirror gain
// - gain select sets maximum current
// - higher gain raises on-resistance, lowers limit
// - sense disabled with the input command
//
// Added by the designer: the placing of the registers and strobed register access.
module hbc_bridge_ctrl
  import hbc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pin_bridge_input_a,
  input wire logic pin_bridge_input_b,
  input wire logic sleep_request_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic bridge_terminal_a_out,
  output logic bridge_terminal_a_oe_n,
  output logic bridge_terminal_b_out,
  output logic bridge_terminal_b_oe_n,
  output logic current_sense_enable,
  output hbc_gain_s gain
);

  // ----------------------------------------
  // state carrier
  // ----------------------------------------
  typedef enum logic [2:0] {
    LEG_IDLE = 3'b001,
    LEG_DEAD = 3'b010,
    LEG_RUN = 3'b100
  } hbc_leg_e;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] gain_sel;
    logic [7:0] rdata;
    logic [2:0] sleep_sync;
    logic sleep_level;
    logic [3:0] ctl_sync1;
    logic [3:0] ctl_sync2;
    hbc_drive_s target;
    hbc_drive_s drive;
    hbc_leg_e leg_a;
    hbc_leg_e leg_b;
    logic [CNT_W-1:0] dead_a;
    logic [CNT_W-1:0] dead_b;
    logic sense_en;
    hbc_gain_s gain;
  } hbc_state_s;

  hbc_state_s st_reg;
  hbc_state_s st_next;

  logic pin_a_clean;
  logic pin_b_clean;
  logic in_a;
  logic in_b;
  logic src_sel;
  logic scheme_sel;
  hbc_bridge_e bridge_cmd;
  hbc_drive_s cmd_drive;
  hbc_gain_s gain_dec;

  // ----------------------------------------
  // pin conditioning
  // ----------------------------------------
  hbc_deglitch u_dg_a (
    .core_clk(core_clk),
    .rst(rst),
    .pin(pin_bridge_input_a),
    .level(pin_a_clean)
  );

  hbc_deglitch u_dg_b (
    .core_clk(core_clk),
    .rst(rst),
    .pin(pin_bridge_input_b),
    .level(pin_b_clean)
  );

  hbc_gain_decode u_gain (
    .gain_select(st_reg.gain_sel),
    .gain(gain_dec)
  );

  // ----------------------------------------
  // functions
  // ----------------------------------------
  // bridge state to per-terminal drive
  function automatic hbc_drive_s drive_of(input hbc_bridge_e b);
    hbc_drive_s d;
    d = '{TERM_Z, TERM_Z};
    case (b)
      BR_REVERSE: d = '{TERM_LOW, TERM_HIGH};
      BR_FORWARD: d = '{TERM_HIGH, TERM_LOW};
      BR_BRAKE: d = '{TERM_LOW, TERM_LOW};
      default: d = '{TERM_Z, TERM_Z};
    endcase
    return d;
  endfunction : drive_of

  // a reversal between high and low needs a dead interval first
  function automatic logic needs_dead(input hbc_term_e cur, input hbc_term_e nxt);
    return ((cur == TERM_HIGH) && (nxt == TERM_LOW)) ||
           ((cur == TERM_LOW) && (nxt == TERM_HIGH));
  endfunction : needs_dead

  // ----------------------------------------
  // input selection and truth tables
  // ----------------------------------------
  // the sync2 stage holds control bits two flops after the register write
  always_comb begin
    src_sel = st_reg.ctl_sync2[CTRL_SRC_BIT];
    scheme_sel = st_reg.ctl_sync2[CTRL_SCHEME_BIT];
    in_a = src_sel ? st_reg.ctl_sync2[CTRL_IN_A_BIT] : pin_a_clean;
    in_b = src_sel ? st_reg.ctl_sync2[CTRL_IN_B_BIT] : pin_b_clean;
    bridge_cmd = BR_SLEEP;
    if (!st_reg.sleep_level) begin
      bridge_cmd = BR_SLEEP;
    end else if (!scheme_sel) begin
      if (!in_a) begin
        bridge_cmd = BR_BRAKE;
      end else if (in_b) begin
        bridge_cmd = BR_FORWARD;
      end else begin
        bridge_cmd = BR_REVERSE;
      end
    end else begin
      case ({in_a, in_b})
        2'b00: bridge_cmd = BR_COAST;
        2'b01: bridge_cmd = BR_REVERSE;
        2'b10: bridge_cmd = BR_FORWARD;
        default: bridge_cmd = BR_BRAKE;
      endcase
    end
    cmd_drive = drive_of(bridge_cmd);
  end

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb begin
    st_next = st_reg;
    // sleep pin: three flops, change counts when last two agree
    st_next.sleep_sync = {st_reg.sleep_sync[1:0], sleep_request_n};
    if (st_reg.sleep_sync[1] == st_reg.sleep_sync[2]) begin
      st_next.sleep_level = st_reg.sleep_sync[2];
    end
    // register bits pass two flops so the source swap lands in one cycle
    st_next.ctl_sync1 = st_reg.ctrl[3:0];
    st_next.ctl_sync2 = st_reg.ctl_sync1;
    st_next.target = cmd_drive;
    // registered decode, so the gain output never shows decode glitches
    st_next.gain = gain_dec;
    // register writes
    if (reg_wr) begin
      case (reg_addr)
        ADDR_CTRL: st_next.ctrl = reg_wdata;
        ADDR_GAIN: st_next.gain_sel = reg_wdata[2:0];
        default: st_next.ctrl = st_reg.ctrl;
      endcase
    end
    // register reads, data valid the cycle after the strobe
    st_next.rdata = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        ADDR_CTRL: st_next.rdata = {4'h0, st_reg.ctrl[3:0]};
        ADDR_GAIN: st_next.rdata = {5'h00, st_reg.gain_sel};
        ADDR_STATUS: st_next.rdata = {st_reg.sense_en, st_reg.sleep_level,
                                      st_reg.drive.term_a, st_reg.drive.term_b, 2'h0};
        default: st_next.rdata = 8'h00;
      endcase
    end
    // leg a: release to high-Z for the dead count before reversing
    case (st_reg.leg_a)
      LEG_DEAD: begin
        st_next.drive.term_a = TERM_Z;
        if (st_reg.dead_a <= CNT_ONE) begin
          st_next.leg_a = LEG_RUN;
          st_next.dead_a = CNT_ZERO;
        end else begin
          st_next.dead_a = st_reg.dead_a - CNT_ONE;
        end
      end
      LEG_IDLE, LEG_RUN: begin
        if (needs_dead(st_reg.drive.term_a, st_reg.target.term_a)) begin
          st_next.drive.term_a = TERM_Z;
          st_next.leg_a = LEG_DEAD;
          st_next.dead_a = DEAD_CNT;
        end else begin
          st_next.drive.term_a = st_reg.target.term_a;
          st_next.leg_a = LEG_RUN;
        end
      end
      default: st_next.leg_a = LEG_IDLE;
    endcase
    // leg b: same dead-time handling
    case (st_reg.leg_b)
      LEG_DEAD: begin
        st_next.drive.term_b = TERM_Z;
        if (st_reg.dead_b <= CNT_ONE) begin
          st_next.leg_b = LEG_RUN;
          st_next.dead_b = CNT_ZERO;
        end else begin
          st_next.dead_b = st_reg.dead_b - CNT_ONE;
        end
      end
      LEG_IDLE, LEG_RUN: begin
        if (needs_dead(st_reg.drive.term_b, st_reg.target.term_b)) begin
          st_next.drive.term_b = TERM_Z;
          st_next.leg_b = LEG_DEAD;
          st_next.dead_b = DEAD_CNT;
        end else begin
          st_next.drive.term_b = st_reg.target.term_b;
          st_next.leg_b = LEG_RUN;
        end
      end
      default: st_next.leg_b = LEG_IDLE;
    endcase
    // sleep overrides any pending drive at once
    if (!st_reg.sleep_level) begin
      st_next.drive = '{TERM_Z, TERM_Z};
      st_next.leg_a = LEG_IDLE;
      st_next.leg_b = LEG_IDLE;
    end
    // sense follows the command, not the slower transistor release
    st_next.sense_en = (cmd_drive.term_a == TERM_LOW) ||
                       (cmd_drive.term_b == TERM_LOW);
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      st_reg <= '{ctrl: CTRL_RESET, gain_sel: GAIN_RESET, rdata: 8'h00,
                  sleep_sync: 3'h0, sleep_level: 1'b0, ctl_sync1: 4'h0,
                  ctl_sync2: 4'h0, target: '{TERM_Z, TERM_Z},
                  drive: '{TERM_Z, TERM_Z}, leg_a: LEG_IDLE, leg_b: LEG_IDLE,
                  dead_a: CNT_ZERO, dead_b: CNT_ZERO, sense_en: 1'b0, gain: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------
  // outputs; oe_n low while driving
  // ----------------------------------------
  assign reg_rdata = st_reg.rdata;
  assign bridge_terminal_a_out = (st_reg.drive.term_a == TERM_HIGH);
  assign bridge_terminal_a_oe_n = (st_reg.drive.term_a == TERM_Z);
  assign bridge_terminal_b_out = (st_reg.drive.term_b == TERM_HIGH);
  assign bridge_terminal_b_oe_n = (st_reg.drive.term_b == TERM_Z);
  assign current_sense_enable = st_reg.sense_en;
  assign gain = st_reg.gain;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence leg_a_reverses;
    (st_reg.drive.term_a == TERM_HIGH) ##1 (st_reg.drive.term_a == TERM_LOW);
  endsequence

  sequence leg_a_rises;
    (st_reg.drive.term_a == TERM_LOW) ##1 (st_reg.drive.term_a == TERM_HIGH);
  endsequence

  sequence leg_b_rises;
    (st_reg.drive.term_b == TERM_LOW) ##1 (st_reg.drive.term_b == TERM_HIGH);
  endsequence

  sleep_hiz_a: assert property (@(posedge core_clk) disable iff (rst)
    !st_reg.sleep_level |=> bridge_terminal_a_oe_n && bridge_terminal_b_oe_n)
    else $error("terminal driven during sleep");

  no_shoot_a: assert property (@(posedge core_clk) disable iff (rst)
    not leg_a_reverses)
    else $error("terminal a reversed without dead time");

  no_rise_a_a: assert property (@(posedge core_clk) disable iff (rst)
    not leg_a_rises)
    else $error("terminal a rose without dead time");

  no_shoot_b_a: assert property (@(posedge core_clk) disable iff (rst)
    !((st_reg.drive.term_b == TERM_LOW) && ($past(st_reg.drive.term_b) == TERM_HIGH)))
    else $error("terminal b reversed without dead time");

  no_rise_b_a: assert property (@(posedge core_clk) disable iff (rst)
    not leg_b_rises)
    else $error("terminal b rose without dead time");

  dead_length_a: assert property (@(posedge core_clk) disable iff (rst)
    (st_reg.leg_a == LEG_RUN) ##1 (st_reg.leg_a == LEG_DEAD) |->
    (st_reg.leg_a == LEG_DEAD) [*8] ##1 (st_reg.leg_a != LEG_DEAD))
    else $error("dead interval length wrong");

  dead_length_b_a: assert property (@(posedge core_clk) disable iff (rst)
    (st_reg.leg_b == LEG_RUN) ##1 (st_reg.leg_b == LEG_DEAD) |->
    (st_reg.leg_b == LEG_DEAD) [*8] ##1 (st_reg.leg_b != LEG_DEAD))
    else $error("leg b dead interval length wrong");

  pwm_coast_a: assert property (@(posedge core_clk) disable iff (rst)
    st_reg.sleep_level && scheme_sel && !in_a && !in_b |=>
    st_reg.target == hbc_drive_s'{TERM_Z, TERM_Z})
    else $error("pwm coast not high impedance");

  pwm_reverse_a: assert property (@(posedge core_clk) disable iff (rst)
    st_reg.sleep_level && scheme_sel && !in_a && in_b |=>
    st_reg.target == hbc_drive_s'{TERM_LOW, TERM_HIGH})
    else $error("pwm reverse decode wrong");

  phen_brake_a: assert property (@(posedge core_clk) disable iff (rst)
    st_reg.sleep_level && !scheme_sel && !in_a |=>
    st_reg.target == hbc_drive_s'{TERM_LOW, TERM_LOW})
    else $error("enable low did not brake");

  forward_map_a: assert property (@(posedge core_clk) disable iff (rst)
    st_reg.sleep_level && in_a && !in_b && scheme_sel |=>
    st_reg.target == hbc_drive_s'{TERM_HIGH, TERM_LOW})
    else $error("pwm forward decode wrong");

  source_sel_a: assert property (@(posedge core_clk) disable iff (rst)
    src_sel |-> in_a == st_reg.ctl_sync2[CTRL_IN_A_BIT])
    else $error("register input not selected");

  sense_off_a: assert property (@(posedge core_clk) disable iff (rst)
    (cmd_drive.term_a != TERM_LOW) && (cmd_drive.term_b != TERM_LOW) |=>
    !current_sense_enable)
    else $error("sense stayed on after low sides commanded off");

  sense_on_a: assert property (@(posedge core_clk) disable iff (rst)
    (cmd_drive.term_a == TERM_LOW) || (cmd_drive.term_b == TERM_LOW) |=>
    current_sense_enable)
    else $error("sense off while a low side is commanded on");

  gain_top_a: assert property (@(posedge core_clk) disable iff (rst)
    st_reg.gain_sel[2] |=> gain.mirror_gain == GAIN_HIGH &&
    gain.overcurrent_limit == OCP_160MA)
    else $error("top gain decode wrong");

endmodule : hbc_bridge_ctrl

// ===== tb/hbc_host_model.sv
// host controller model: drives the bridge input pins and the sleep pin
module hbc_host_model
  import hbc_pkg::*;
(
  input wire logic core_clk,
  output logic pin_bridge_input_a,
  output logic pin_bridge_input_b,
  output logic sleep_request_n
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // asleep and idle from time zero, like a host still booting
  initial begin
    pin_bridge_input_a = 1'b0;
    pin_bridge_input_b = 1'b0;
    sleep_request_n = 1'b0;
  end

  // pins move just after a rising edge, as a port write would
  task automatic set_pins(input logic a, input logic b);
    @(posedge core_clk);
    pin_bridge_input_a <= a;
    pin_bridge_input_b <= b;
  endtask : set_pins

  task automatic set_sleep_n(input logic v);
    @(posedge core_clk);
    sleep_request_n <= v;
  endtask : set_sleep_n

  // short inversion of input a, far below the filter span
  task automatic glitch_a(input int len);
    @(posedge core_clk);
    pin_bridge_input_a <= ~pin_bridge_input_a;
    repeat (len) @(posedge core_clk);
    pin_bridge_input_a <= ~pin_bridge_input_a;
  endtask : glitch_a

  // coast current is invisible, so brake briefly to let the sense path see it
  task automatic sense_pulse(input int len);
    set_pins(1'b1, 1'b1);
    repeat (len) @(posedge core_clk);
    set_pins(1'b0, 1'b0);
  endtask : sense_pulse
endmodule : hbc_host_model

// ===== tb/hbc_bridge_ctrl_tb_top.sv
// testbench top: register and pin driven checks of the bridge control block
module hbc_bridge_ctrl_tb_top
  import hbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------
  // signals and instances
  // ----------------------------------------
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pin_a, pin_b, sleep_n;
  logic a_out, a_oe_n, b_out, b_oe_n, sense_en;
  hbc_gain_s gain;
  int bad_count = 0;
  int n_checks = 0;

  always #12.5 core_clk = ~core_clk;

  hbc_host_model hbc_host_model_i (
    .core_clk(core_clk),
    .pin_bridge_input_a(pin_a),
    .pin_bridge_input_b(pin_b),
    .sleep_request_n(sleep_n)
  );

  hbc_bridge_ctrl hbc_bridge_ctrl_i (
    .core_clk(core_clk),
    .rst(rst),
    .pin_bridge_input_a(pin_a),
    .pin_bridge_input_b(pin_b),
    .sleep_request_n(sleep_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .bridge_terminal_a_out(a_out),
    .bridge_terminal_a_oe_n(a_oe_n),
    .bridge_terminal_b_out(b_out),
    .bridge_terminal_b_oe_n(b_oe_n),
    .current_sense_enable(sense_en),
    .gain(gain)
  );

  // ----------------------------------------
  // bus tasks and compares
  // ----------------------------------------
  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // read data stands only in the cycle after the strobe
  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : reg_read

  task automatic settle(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic check_bit(input string name, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %b seen %b", name, e, g);
    end
  endtask : check_bit

  task automatic check_byte(input string name, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, e, g);
    end
  endtask : check_byte

  task automatic check_gain(input hbc_gain_s e);
    n_checks++;
    if (gain !== e) begin
      bad_count++;
      $display("mismatch gain expected %h seen %h", e, gain);
    end
  endtask : check_gain

  // pins and the status word must agree with the expected bridge state
  task automatic check_bridge(input hbc_term_e ea, input hbc_term_e eb, input logic es,
                              input logic awake);
    logic [7:0] d;
    check_bit("a oe_n", ea == TERM_Z, a_oe_n);
    check_bit("b oe_n", eb == TERM_Z, b_oe_n);
    if (ea != TERM_Z) check_bit("a out", ea == TERM_HIGH, a_out);
    if (eb != TERM_Z) check_bit("b out", eb == TERM_HIGH, b_out);
    check_bit("sense", es, sense_en);
    reg_read(ADDR_STATUS, d);
    check_byte("status", {es, awake, ea, eb, 2'b00}, {d[7:2], 2'b00});
  endtask : check_bridge

  function automatic hbc_gain_s exp_gain(input logic [2:0] s);
    hbc_gain_s g;
    g.mirror_gain = s[2] ? GAIN_HIGH : (s[1] ? GAIN_MID : GAIN_LOW);
    g.low_side_rds = s[2] ? RDS_2040 : (s[1] ? RDS_440 : RDS_120);
    g.overcurrent_limit = s[2] ? OCP_160MA : (s[1] ? OCP_800MA : OCP_4A);
    g.max_current = s[2] ? (s[0] ? IMAX_125MA : IMAX_250MA) :
                    (s[1] ? (s[0] ? IMAX_500MA : IMAX_1A) : (s[0] ? IMAX_2A : IMAX_4A));
    return g;
  endfunction : exp_gain

  task automatic complete_run();
    if (bad_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  // table index is {input a, input b}
  initial begin
    logic [7:0] d;
    static hbc_term_e pwm_a [4] = '{TERM_Z, TERM_LOW, TERM_HIGH, TERM_LOW};
    static hbc_term_e pwm_b [4] = '{TERM_Z, TERM_HIGH, TERM_LOW, TERM_LOW};
    static hbc_term_e phen_a [4] = '{TERM_LOW, TERM_LOW, TERM_LOW, TERM_HIGH};
    static hbc_term_e phen_b [4] = '{TERM_LOW, TERM_LOW, TERM_HIGH, TERM_LOW};
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    reg_read(ADDR_CTRL, d);
    check_byte("ctrl reset", CTRL_RESET, d);
    reg_read(ADDR_GAIN, d);
    check_byte("gain reset", {5'h00, GAIN_RESET}, d);
    reg_write(4'hf, 8'hff);
    reg_read(4'hf, d);
    check_byte("unmapped", 8'h00, d);
    reg_read(ADDR_CTRL, d);
    check_byte("ctrl kept", CTRL_RESET, d);
    // forward commanded from registers while asleep
    reg_write(ADDR_CTRL, 8'h07);
    settle(30);
    check_bridge(TERM_Z, TERM_Z, 1'b0, 1'b0);
    hbc_host_model_i.set_sleep_n(1'b1);
    for (int i = 0; i < 4; i++) begin
      reg_write(ADDR_CTRL, 8'h03 | {4'h0, i[0], i[1], 2'b00});
      settle(20);
      check_bridge(pwm_a[i], pwm_b[i], i != 0, 1'b1);
    end
    // reverse then forward: both legs must pass through high impedance
    reg_write(ADDR_CTRL, 8'h0b);
    settle(20);
    reg_write(ADDR_CTRL, 8'h07);
    settle(6);
    check_bit("a dead", 1'b1, a_oe_n);
    check_bit("b dead", 1'b1, b_oe_n);
    settle(10);
    check_bridge(TERM_HIGH, TERM_LOW, 1'b1, 1'b1);
    for (int i = 0; i < 4; i++) begin
      reg_write(ADDR_CTRL, 8'h01 | {4'h0, i[0], i[1], 2'b00});
      settle(20);
      check_bridge(phen_a[i], phen_b[i], 1'b1, 1'b1);
    end
    // pin source, PWM scheme
    reg_write(ADDR_CTRL, 8'h02);
    hbc_host_model_i.set_pins(1'b1, 1'b0);
    settle(40);
    check_bridge(TERM_HIGH, TERM_LOW, 1'b1, 1'b1);
    hbc_host_model_i.glitch_a(5);
    settle(40);
    check_bridge(TERM_HIGH, TERM_LOW, 1'b1, 1'b1);
    hbc_host_model_i.set_pins(1'b0, 1'b0);
    settle(40);
    check_bridge(TERM_Z, TERM_Z, 1'b0, 1'b1);
    fork
      hbc_host_model_i.sense_pulse(60);
      begin
        settle(45);
        check_bit("sense pulse", 1'b1, sense_en);
      end
    join
    settle(40);
    check_bridge(TERM_Z, TERM_Z, 1'b0, 1'b1);
    // pin source, phase/enable scheme
    reg_write(ADDR_CTRL, 8'h00);
    hbc_host_model_i.set_pins(1'b1, 1'b0);
    settle(40);
    check_bridge(TERM_LOW, TERM_HIGH, 1'b1, 1'b1);
    hbc_host_model_i.set_sleep_n(1'b0);
    settle(12);
    check_bridge(TERM_Z, TERM_Z, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      reg_write(ADDR_GAIN, 8'(i));
      settle(2);
      check_gain(exp_gain(3'(i)));
      reg_read(ADDR_GAIN, d);
      check_byte("gain back", 8'(i), d);
    end
    complete_run();
  end

  // the whole sequence needs about six hundred and fifty cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end
endmodule : hbc_bridge_ctrl_tb_top
